// file: hdl/ldo_ctrl_pkg.sv
package ldo_ctrl_pkg;

    // Regulator indices within the six-wide vectors
    localparam int NUM_REG       = 6;
    localparam int NUM_PROT      = 5;
    localparam int IDX_DAC       = 0;
    localparam int IDX_USB       = 1;
    localparam int IDX_USB2      = 2;
    localparam int IDX_GEN1      = 3;
    localparam int IDX_GEN2      = 4;
    localparam int IDX_PLL       = 5;

    // Register offsets (word index on the plain port)
    localparam logic [3:0] OFS_ENABLE   = 4'h0;
    localparam logic [3:0] OFS_STBYSEL  = 4'h1;
    localparam logic [3:0] OFS_CONTROL  = 4'h2;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h4;
    localparam logic [3:0] OFS_STATUS   = 4'h5;

    // Control register fields
    localparam int CTL_PROT_EN   = 0;
    localparam int CTL_PLL_SEL   = 1;

    // Interrupt status/mask fields
    localparam int IRQ_SHORT     = 0;

    // Reset values
    localparam logic [5:0] RST_ENABLE  = 6'h00;
    localparam logic [5:0] RST_STBYSEL = 6'h00;
    localparam logic       RST_PROT_EN = 1'b0;
    localparam logic [1:0] RST_PLL_SEL = 2'h0;
    localparam logic       RST_MASK    = 1'b1;

    // Fault debounce: time in microseconds, count in 50 ns cycles
    localparam int CLK_MHZ          = 20;
    localparam int DEBOUNCE_US      = 32;
    localparam int DEBOUNCE_CYCLES  = DEBOUNCE_US * CLK_MHZ;
    localparam int DEB_W            = 10;

    // PLL supply output in millivolts, indexed by the select code
    localparam logic [11:0] PLL_MV_00 = 12'h4b0;
    localparam logic [11:0] PLL_MV_01 = 12'h4e2;
    localparam logic [11:0] PLL_MV_10 = 12'h5dc;
    localparam logic [11:0] PLL_MV_11 = 12'h708;

endpackage

// file: hdl/fault_debounce.sv
`timescale 1ns/1ps
module fault_debounce (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Raw fault pin and debounced result
    input  wire logic fault_raw,
    output logic      fault_det
);

    typedef struct packed {
        logic [2:0]                    sync;
        logic [ldo_ctrl_pkg::DEB_W-1:0] cnt;
        logic                          det;
    } deb_state_t;

    deb_state_t st;
    deb_state_t next_st;

    localparam logic [ldo_ctrl_pkg::DEB_W-1:0] CNT_MAX =
        ldo_ctrl_pkg::DEB_W'(ldo_ctrl_pkg::DEBOUNCE_CYCLES - 1);

    always_comb begin
        next_st      = st;
        next_st.sync = {st.sync[1:0], fault_raw};
        // Only stages two and three are compared; stage one may be metastable
        if (st.sync[2] != st.sync[1]) begin
            next_st.cnt = '0;
        end else if (st.sync[2] == st.det) begin
            next_st.cnt = '0;
        end else if (st.cnt == CNT_MAX) begin
            next_st.det = st.sync[2];
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fault_det = st.det;

endmodule

// file: hdl/ldo_enable_short_protect.sv
// Operation
// - Internal-pass regulator on when enabled, off if standby-selected during standby.
// - Standby condition comes from the chip-wide standby event input.
// - Short protection covers DAC, both USB and both general supplies only.
// - Each overcurrent fault is debounced before it counts as a short.
// - Detected short with protection on clears that regulator's enable bit.
// - Same event raises the short-circuit interrupt flag.
// - A set mask bit blocks the short-circuit interrupt request.
// - With global protection clear, shorts neither clear enables nor flag.
// - Global protection enable is clear after reset.
// - PLL select decodes 00/01/10/11 to 1.2/1.25/1.50/1.8 V.
// - Control register reads return programmed bits; the status register reads live state.
// - Each regulator has its own standby select; clear means standby ignored.
`timescale 1ns/1ps
module ldo_enable_short_protect (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Power-saving standby event
    input  wire logic        standby_event,
    // Raw overcurrent flags of the protected regulators
    input  wire logic [4:0]  overcurrent_raw,
    // Regulator drive and PLL setting
    output logic      [5:0]  regulator_on,
    output logic      [11:0] pll_supply_mv,
    // Interrupt
    output logic             irq
);

    typedef struct packed {
        logic [5:0]  regulator_enable_bit;
        logic [5:0]  standby_off_select;
        logic        short_protect_global_enable;
        logic [1:0]  pll_supply_voltage_select;
        logic        short_circuit_irq_flag;
        logic        short_circuit_irq_mask;
        logic [2:0]  stby_sync;
        logic        stby_level;
        logic [5:0]  reg_on;
        logic [11:0] pll_mv;
        logic        irq;
        logic [7:0]  rdata;
    } ctl_state_t;

    ctl_state_t st;
    ctl_state_t next_st;

    logic [4:0] short_det;
    logic       stby_now;

    // One debouncer per protected regulator
    genvar g;
    generate
        for (g = 0; g < ldo_ctrl_pkg::NUM_PROT; g++) begin : g_deb
            fault_debounce u_deb (
                .mclk      (mclk),
                .rst_n     (rst_n),
                .fault_raw (overcurrent_raw[g]),
                .fault_det (short_det[g])
            );
        end
    endgenerate

    // Standby is a pin-level input; a one-cycle glitch must not count
    assign stby_now = (st.stby_sync[2] == st.stby_sync[1]) ?
                      st.stby_sync[2] : st.stby_level;

    always_comb begin
        logic [5:0] kill;
        logic       fault_evt;
        logic [5:0] en_after;
        logic [7:0] rd;
        kill      = '0;
        fault_evt = 1'b0;
        en_after  = '0;
        rd        = '0;
        next_st   = st;

        next_st.stby_sync  = {st.stby_sync[1:0], standby_event};
        next_st.stby_level = stby_now;

        // Short shutdown only under global enable; PLL is never touched
        if (st.short_protect_global_enable) begin
            kill[ldo_ctrl_pkg::NUM_PROT-1:0] = short_det;
            fault_evt = |short_det;
        end

        // Software writes
        en_after = st.regulator_enable_bit;
        if (reg_wr) begin
            unique case (reg_addr)
                ldo_ctrl_pkg::OFS_ENABLE:
                    en_after = reg_wdata[5:0];
                ldo_ctrl_pkg::OFS_STBYSEL:
                    next_st.standby_off_select = reg_wdata[5:0];
                ldo_ctrl_pkg::OFS_CONTROL: begin
                    next_st.short_protect_global_enable =
                        reg_wdata[ldo_ctrl_pkg::CTL_PROT_EN];
                    next_st.pll_supply_voltage_select =
                        reg_wdata[ldo_ctrl_pkg::CTL_PLL_SEL +: 2];
                end
                ldo_ctrl_pkg::OFS_IRQ_STAT:
                    if (reg_wdata[ldo_ctrl_pkg::IRQ_SHORT]) begin
                        next_st.short_circuit_irq_flag = 1'b0;
                    end
                ldo_ctrl_pkg::OFS_IRQ_MASK:
                    next_st.short_circuit_irq_mask =
                        reg_wdata[ldo_ctrl_pkg::IRQ_SHORT];
                default: ;
            endcase
        end
        // Hardware shutdown beats a simultaneous software write
        next_st.regulator_enable_bit = en_after & ~kill;
        // Set wins over clear; flag ignores the mask
        if (fault_evt) begin
            next_st.short_circuit_irq_flag = 1'b1;
        end

        // Live regulator state from enable, standby select and standby condition only
        for (int i = 0; i < ldo_ctrl_pkg::NUM_REG; i++) begin
            next_st.reg_on[i] = next_st.regulator_enable_bit[i] &
                ~(next_st.standby_off_select[i] & stby_now);
        end

        unique case (next_st.pll_supply_voltage_select)
            2'h0:    next_st.pll_mv = ldo_ctrl_pkg::PLL_MV_00;
            2'h1:    next_st.pll_mv = ldo_ctrl_pkg::PLL_MV_01;
            2'h2:    next_st.pll_mv = ldo_ctrl_pkg::PLL_MV_10;
            2'h3:    next_st.pll_mv = ldo_ctrl_pkg::PLL_MV_11;
        endcase

        next_st.irq = next_st.short_circuit_irq_flag &
                      ~next_st.short_circuit_irq_mask;

        // Reads show programmed bits; live state has its own register
        if (reg_rd) begin
            unique case (reg_addr)
                ldo_ctrl_pkg::OFS_ENABLE:
                    rd = {2'h0, st.regulator_enable_bit};
                ldo_ctrl_pkg::OFS_STBYSEL:
                    rd = {2'h0, st.standby_off_select};
                ldo_ctrl_pkg::OFS_CONTROL:
                    rd = {5'h00, st.pll_supply_voltage_select,
                          st.short_protect_global_enable};
                ldo_ctrl_pkg::OFS_IRQ_STAT:
                    rd = {7'h00, st.short_circuit_irq_flag};
                ldo_ctrl_pkg::OFS_IRQ_MASK:
                    rd = {7'h00, st.short_circuit_irq_mask};
                ldo_ctrl_pkg::OFS_STATUS:
                    rd = {2'h0, st.reg_on};
                default:
                    rd = 8'h00;
            endcase
        end
        next_st.rdata = rd;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.regulator_enable_bit        <= ldo_ctrl_pkg::RST_ENABLE;
            st.standby_off_select          <= ldo_ctrl_pkg::RST_STBYSEL;
            st.short_protect_global_enable <= ldo_ctrl_pkg::RST_PROT_EN;
            st.pll_supply_voltage_select   <= ldo_ctrl_pkg::RST_PLL_SEL;
            st.short_circuit_irq_mask      <= ldo_ctrl_pkg::RST_MASK;
            st.pll_mv                      <= ldo_ctrl_pkg::PLL_MV_00;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata     = st.rdata;
    assign regulator_on  = st.reg_on;
    assign pll_supply_mv = st.pll_mv;
    assign irq           = st.irq;

endmodule

// file: sim/ldo_enable_short_protect_monitor.sv
`timescale 1ns/1ps
module ldo_enable_short_protect_monitor (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Events and outputs
    input wire logic        standby_event,
    input wire logic [4:0]  overcurrent_raw,
    input wire logic [5:0]  regulator_on,
    input wire logic [11:0] pll_supply_mv,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // PLL supply has no protection, so only writes and standby move it
    sequence s_pll_on_written;
        reg_wr && reg_addr == 4'h0 && reg_wdata[5];
    endsequence
    chk_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read");
    chk_unmapped_read:
        assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_status_read:
        assert property (reg_rd && reg_addr == 4'h5
            |=> reg_rdata == {2'b00, $past(regulator_on)})
        else $error("status read wrong");
    chk_pll_decode:
        assert property (reg_wr && reg_addr == 4'h2 |=> pll_supply_mv ==
            ($past(reg_wdata[2]) ? ($past(reg_wdata[1]) ? 12'h708 : 12'h5dc)
                                 : ($past(reg_wdata[1]) ? 12'h4e2 : 12'h4b0)))
        else $error("pll voltage decode wrong");
    chk_pll_off:
        assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[5]
            |=> !regulator_on[5])
        else $error("pll supply on while disabled");
    chk_pll_on:
        assert property (s_pll_on_written ##1 (!reg_wr && !standby_event)[*5]
            |-> regulator_on[5])
        else $error("pll supply off while enabled");
    chk_mask_blocks:
        assert property (reg_wr && reg_addr == 4'h4 && reg_wdata[0] |=> !irq)
        else $error("irq while masked");
    chk_reset_vals:
        assert property ($rose(rst_n) |-> regulator_on == 6'h00 && !irq
            && pll_supply_mv == 12'h4b0)
        else $error("outputs wrong after reset");
endmodule
bind ldo_enable_short_protect ldo_enable_short_protect_monitor
    ldo_enable_short_protect_monitor_i (.mclk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .standby_event, .overcurrent_raw,
    .regulator_on, .pll_supply_mv, .irq);

// file: sim/ldo_enable_short_protect_test.sv
`timescale 1ns/1ps
module ldo_enable_short_protect_test;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        standby_event = 1'b0;
    logic [4:0]  overcurrent_raw = 5'h00;
    logic [5:0]  regulator_on;
    logic [11:0] pll_supply_mv;
    logic        irq;
    int          error_cnt = 0;
    int          n_compared = 0;
    logic [7:0]  d;
    logic [5:0]  en, sel, on;
    logic        sb;
    logic [1:0]  ps;
    logic [11:0] mv;
    // Enable, standby select, standby, PLL select, expected on, expected mV
    logic [32:0] rows [5] = '{
        {6'h3f, 6'h00, 1'b0, 2'h0, 6'h3f, 12'h4b0},
        {6'h3f, 6'h00, 1'b1, 2'h1, 6'h3f, 12'h4e2},
        {6'h3f, 6'h2a, 1'b1, 2'h2, 6'h15, 12'h5dc},
        {6'h0a, 6'h0f, 1'b0, 2'h3, 6'h0a, 12'h708},
        {6'h0a, 6'h3f, 1'b1, 2'h3, 6'h00, 12'h708}};
    ldo_enable_short_protect ldo_enable_short_protect_i (.*);
    always #25 mclk = ~mclk;
    task wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask
    task cmp(input logic [11:0] g, input logic [11:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Debounce alone needs 640 cycles twice; ample margin
    initial begin
        #500000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        cmp(regulator_on, 6'h00);
        cmp(pll_supply_mv, 12'h4b0);
        cmp(irq, 1'b0);
        rd(4'h2);
        cmp(d, 8'h00);
        rd(4'h4);
        cmp(d, 8'h01);
        rd(4'h5);
        cmp(d, 8'h00);
        rd(4'hf);
        cmp(d, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            {en, sel, sb, ps, on, mv} = rows[i];
            standby_event <= sb;
            wr(4'h0, {2'h0, en});
            wr(4'h1, {2'h0, sel});
            wr(4'h2, {5'h00, ps, 1'b0});
            repeat (8) @(posedge mclk);
            cmp(regulator_on, on);
            cmp(pll_supply_mv, mv);
            rd(4'h0);
            cmp(d, {2'h0, en});
            rd(4'h1);
            cmp(d, {2'h0, sel});
        end
        $display("row test done");
        standby_event <= 1'b0;
        wr(4'h0, 8'h3f);
        overcurrent_raw <= 5'h1f;
        repeat (700) @(posedge mclk);
        rd(4'h0);
        cmp(d, 8'h3f);
        rd(4'h3);
        cmp(d, 8'h00);
        wr(4'h2, 8'h01);
        repeat (4) @(posedge mclk);
        cmp(regulator_on, 6'h20);
        rd(4'h0);
        cmp(d, 8'h20);
        rd(4'h3);
        cmp(d, 8'h01);
        cmp(irq, 1'b0);
        wr(4'h4, 8'h00);
        repeat (2) @(posedge mclk);
        cmp(irq, 1'b1);
        overcurrent_raw <= 5'h00;
        repeat (700) @(posedge mclk);
        wr(4'h4, 8'h01);
        rd(4'h3);
        cmp(d, 8'h01);
        cmp(irq, 1'b0);
        wr(4'h3, 8'h01);
        rd(4'h3);
        cmp(d, 8'h00);
        $display("short test done");
        end_of_test();
    end
endmodule
